// file: logic/mbt_pkg.sv
// Purpose: constants for the coded serial output transmitter
// Assumes: byte-wide register port, one 125 MHz clock
// Notes: offsets are the device's register addresses
`default_nettype none
package mbt_pkg;
	localparam logic [15:0] ADDR_PORT3_DIR = 16'hff23;
	localparam logic [15:0] ADDR_CTL0 = 16'hff4c;
	localparam logic [15:0] ADDR_CTL1 = 16'hff4d;
	localparam logic [15:0] ADDR_CTL2 = 16'hff4e;
	localparam logic [15:0] ADDR_TXBUF = 16'hff4f;
	localparam logic [15:0] ADDR_BITCNT = 16'hff50;
	localparam logic [15:0] ADDR_STATUS = 16'hff51;
	localparam logic [7:0] RST_PORT3_DIR = 8'hff;
	localparam logic [7:0] RST_CTL0 = 8'h10;
	localparam logic [7:0] RST_CTL1 = 8'h00;
	localparam logic [7:0] RST_CTL2 = 8'h1f;
	localparam logic [7:0] RST_BITCNT = 8'h07;
	localparam int BIT_ENABLE = 7;
	localparam int BIT_FIRST = 4;
	localparam int BIT_FORMAT = 1;
	localparam int BIT_IDLE = 0;
	localparam int BIT_CODED_PIN = 2;
	localparam logic [4:0] K_MIN = 5'h04;
	localparam logic [2:0] SEL_MAX = 3'h5;
	localparam int LATE_RESTART_CLKS = 2;
	typedef enum logic [1:0] {MBT_IDLE, MBT_SEND, MBT_GAP} mbt_state_t;
endpackage : mbt_pkg
`default_nettype wire

// file: logic/mbt_tx.sv
// Purpose: Manchester / bit-sequential serial transmitter with its registers
// Assumes: register writes are single-cycle strobes synchronous to I_CLK
// Notes: base clock and half-bit tick are one-cycle enables from dividers; the baud clock is a toggling level
`default_nettype none
module mbt_tx
	import mbt_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [15:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	output logic [7:0] O_RDATA,
	output logic O_TX_LOAD_IRQ,
	output logic O_CODED_OUT_PIN,
	output logic O_CODED_OUT_OE
);
	import mbt_pkg::*;

	logic [7:0] ctl0_q, ctl1_q, ctl2_q, dir_q, bitcnt_q, txbuf_q;
	logic pending_q;
	logic late_q;
	mbt_state_t state_q;
	logic [5:0] pre_q;
	logic [4:0] kcnt_q;
	logic baud_q;
	logic [2:0] cnt_q;
	logic [7:0] sh_q;
	logic [1:0] gap_q;
	logic busy_q;
	logic enable, base_tick, half_tick, load_now, wr_tx, last_bit;
	logic [4:0] k_eff;
	logic [5:0] pre_div;
	logic data_bit, pin_d;

	assign enable = ctl0_q[BIT_ENABLE];
	assign wr_tx = I_WR && (I_ADDR == ADDR_TXBUF);
	// last bit is the one sent with counter at zero
	assign last_bit = (state_q == MBT_SEND) && (cnt_q == 3'h0);

	// register writes; mode and divider bits are meant to change only while stopped
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ctl0_q <= RST_CTL0;
			ctl1_q <= RST_CTL1;
			ctl2_q <= RST_CTL2;
			dir_q <= RST_PORT3_DIR;
			bitcnt_q <= RST_BITCNT;
			txbuf_q <= 8'h00;
		end else if (I_WR) begin
			case (I_ADDR)
				ADDR_CTL0: ctl0_q <= I_WDATA & 8'h93;
				ADDR_CTL1: ctl1_q <= I_WDATA & 8'h07;
				ADDR_CTL2: ctl2_q <= I_WDATA & 8'h1f;
				ADDR_PORT3_DIR: dir_q <= I_WDATA | 8'he0;
				ADDR_BITCNT: bitcnt_q <= I_WDATA & 8'h07;
				ADDR_TXBUF: txbuf_q <= I_WDATA;
				default: ;
			endcase
		end
	end

	// base clock prescaler, prohibited codes clamp to the slowest
	always_comb begin
		pre_div = 6'h01 << ((ctl1_q[2:0] > SEL_MAX) ? SEL_MAX : ctl1_q[2:0]);
		base_tick = (pre_q == pre_div - 6'h01);
		// codes below four behave as four
		k_eff = (ctl2_q[4:0] < K_MIN) ? K_MIN : ctl2_q[4:0];
		half_tick = base_tick && (kcnt_q == k_eff - 5'h01);
	end

	// dividers run only while enabled so every word starts on a clean phase
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			pre_q <= 6'h00;
			kcnt_q <= 5'h00;
			baud_q <= 1'b0;
		end else if (!enable || load_now) begin
			pre_q <= 6'h00;
			kcnt_q <= 5'h00;
			baud_q <= 1'b0;
		end else begin
			pre_q <= base_tick ? 6'h00 : pre_q + 6'h01;
			if (base_tick) begin
				kcnt_q <= half_tick ? 5'h00 : kcnt_q + 5'h01;
			end
			// second divide by two gives the baud clock
			if (half_tick) begin
				baud_q <= ~baud_q;
			end
		end
	end

	// buffer write starts a word, immediately when idle
	assign load_now = enable && pending_q && ((state_q == MBT_IDLE)
		|| (last_bit && half_tick && baud_q && !late_q)
		|| (state_q == MBT_GAP && base_tick && gap_q == 2'h1));

	// pending word; a new write wins over the load that consumes the old one
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			pending_q <= 1'b0;
			late_q <= 1'b0;
		end else if (!enable) begin
			pending_q <= 1'b0;
			late_q <= 1'b0;
		end else if (wr_tx) begin
			pending_q <= 1'b1;
			// write during the last half bit plus one base clock is late
			late_q <= last_bit && (baud_q || (half_tick && !baud_q)
				|| (kcnt_q == k_eff - 5'h01 && !baud_q));
		end else if (load_now) begin
			pending_q <= 1'b0;
			late_q <= 1'b0;
		end
	end

	// transmit sequencer
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state_q <= MBT_IDLE;
			cnt_q <= 3'h0;
			sh_q <= 8'h00;
			gap_q <= 2'h0;
		end else if (!enable) begin
			state_q <= MBT_IDLE;
		end else if (load_now) begin
			state_q <= MBT_SEND;
			cnt_q <= bitcnt_q[2:0];
			sh_q <= txbuf_q;
		end else if (state_q == MBT_SEND && half_tick && baud_q) begin
			if (cnt_q == 3'h0) begin
				// a buffer write on the closing edge is late as well
				state_q <= (pending_q || wr_tx) ? MBT_GAP : MBT_IDLE;
				gap_q <= 2'(LATE_RESTART_CLKS);
			end else begin
				cnt_q <= cnt_q - 3'h1;
				// shift toward the selected first bit
				sh_q <= ctl0_q[BIT_FIRST] ? {1'b0, sh_q[7:1]} : {sh_q[6:0], 1'b0};
			end
		end else if (state_q == MBT_GAP && base_tick) begin
			gap_q <= gap_q - 2'h1;
		end
	end

	// choose coded or plain output; idle level otherwise
	always_comb begin
		data_bit = ctl0_q[BIT_FIRST] ? sh_q[0] : sh_q[7];
		if (state_q == MBT_SEND && enable) begin
			// with format bit 0 each bit is Manchester coded as data xor baud clock; format bit 1 sends it plain
			pin_d = ctl0_q[BIT_FORMAT] ? data_bit : (data_bit ^ baud_q);
		end else begin
			pin_d = ctl0_q[BIT_IDLE];
		end
	end

	// registered outputs and status
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_CODED_OUT_PIN <= 1'b0;
			O_CODED_OUT_OE <= 1'b0;
			O_TX_LOAD_IRQ <= 1'b0;
			busy_q <= 1'b0;
			O_RDATA <= 8'h00;
		end else begin
			O_CODED_OUT_PIN <= pin_d;
			// output buffer on while direction bit is 0
			O_CODED_OUT_OE <= ~dir_q[BIT_CODED_PIN];
			O_TX_LOAD_IRQ <= load_now;
			busy_q <= enable && (load_now || state_q == MBT_GAP
				|| (state_q == MBT_SEND
				&& !(last_bit && half_tick && baud_q && !(pending_q || wr_tx))));
			case (I_ADDR)
				ADDR_CTL0: O_RDATA <= ctl0_q;
				ADDR_CTL1: O_RDATA <= ctl1_q;
				ADDR_CTL2: O_RDATA <= ctl2_q;
				ADDR_PORT3_DIR: O_RDATA <= dir_q;
				ADDR_BITCNT: O_RDATA <= bitcnt_q;
				ADDR_TXBUF: O_RDATA <= txbuf_q;
				ADDR_STATUS: O_RDATA <= {7'h00, busy_q};
				default: O_RDATA <= 8'h00;
			endcase
		end
	end

	property p_irq_load;
		@(posedge I_CLK) disable iff (!I_ARST_N)
		load_now |=> O_TX_LOAD_IRQ && state_q == MBT_SEND && cnt_q == $past(bitcnt_q[2:0]);
	endproperty
	a_irq_load: assert property (p_irq_load) else $error("irq or load mismatch");

	property p_stop;
		@(posedge I_CLK) disable iff (!I_ARST_N)
		!enable |=> state_q == MBT_IDLE;
	endproperty
	a_stop: assert property (p_stop) else $error("runs while disabled");

	property p_idle;
		@(posedge I_CLK) disable iff (!I_ARST_N)
		(state_q == MBT_IDLE) |=> O_CODED_OUT_PIN == $past(ctl0_q[BIT_IDLE]);
	endproperty
	a_idle: assert property (p_idle) else $error("idle level wrong");

	property p_data;
		@(posedge I_CLK) disable iff (!I_ARST_N)
		(enable && state_q == MBT_SEND && !ctl0_q[BIT_FORMAT]) |=>
			O_CODED_OUT_PIN == ($past(data_bit) ^ $past(baud_q));
	endproperty
	a_data: assert property (p_data) else $error("manchester output wrong");

	property p_plain;
		@(posedge I_CLK) disable iff (!I_ARST_N)
		(enable && state_q == MBT_SEND && ctl0_q[BIT_FORMAT]) |=> O_CODED_OUT_PIN == $past(data_bit);
	endproperty
	a_plain: assert property (p_plain) else $error("plain output wrong");

	property p_count;
		@(posedge I_CLK) disable iff (!I_ARST_N)
		(state_q == MBT_SEND && half_tick && baud_q && cnt_q != 3'h0 && !load_now && enable)
			|=> cnt_q == $past(cnt_q) - 3'h1;
	endproperty
	a_count: assert property (p_count) else $error("counter step wrong");

	property p_oe;
		@(posedge I_CLK) disable iff (!I_ARST_N)
		1'b1 |=> O_CODED_OUT_OE == !$past(dir_q[BIT_CODED_PIN]);
	endproperty
	a_oe: assert property (p_oe) else $error("pin enable wrong");

	property p_busy;
		@(posedge I_CLK) disable iff (!I_ARST_N)
		load_now |=> busy_q;
	endproperty
	a_busy: assert property (p_busy) else $error("busy not set");
endmodule : mbt_tx
`default_nettype wire

// file: verif/mbt_rx_model.sv
// Purpose: receiver model for the coded serial line
// Assumes: half bit period given in clocks, word start marked by the load irq
// Notes: samples mid half-bit, so a skew of a cycle or two is tolerated
`default_nettype none
module mbt_rx_model (
	input wire logic i_clk,
	input wire logic i_irq,
	input wire logic i_pin,
	input wire logic i_plain,
	input wire logic [7:0] i_half,
	input wire logic [3:0] i_nbits,
	output logic [7:0] o_bits,
	output logic [3:0] o_cnt,
	output logic o_bad
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ph;
	logic a;
	// half-bit sampler; stops at the agreed bit count so idle is not read as data
	always @(posedge i_clk) begin
		if (i_irq) begin
			ph <= 8'h00;
			o_cnt <= 4'h0;
			o_bits <= 8'h00;
			o_bad <= 1'b0;
		end else begin
			ph <= (ph == {i_half[6:0], 1'b0} - 8'h01) ? 8'h00 : ph + 8'h01;
			if (o_cnt != i_nbits && ph == (i_half >> 1))
				a <= i_pin;
			if (o_cnt != i_nbits && ph == i_half + (i_half >> 1)) begin
				o_bits <= {o_bits[6:0], a};
				o_cnt <= o_cnt + 4'h1;
				o_bad <= o_bad | (i_plain ? (i_pin != a) : (i_pin == a));
			end
		end
	end
endmodule : mbt_rx_model
`default_nettype wire

// file: verif/mbt_tx_test.sv
// Purpose: register-level test of the coded serial transmitter
// Assumes: a half bit lasts k clocks times the base clock divisor
// Notes: expected bits are built from data, count and order bits
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module mbt_tx_test;
	import mbt_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic plain = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic [7:0] half = 8'h04;
	logic [3:0] nbits = 4'h8;
	logic [7:0] rdata, rx_bits, exp_bits;
	logic [3:0] rx_cnt;
	logic irq, pin, oe, rx_bad;
	int miscompares = 0;
	int num_checks = 0;
	int irqs = 0;
	int cyc = 0;
	int irq_at = 0;
	int irq_gap = 0;
	logic [7:0] prev_bits;
	logic [3:0] prev_cnt;
	logic prev_bad;
	// clock; load pulse tally, spacing, and what the receiver held before each load
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (irq === 1'b1) begin
			irqs++;
			irq_gap = cyc - irq_at;
			irq_at = cyc;
			prev_bits = rx_bits;
			prev_cnt = rx_cnt;
			prev_bad = rx_bad;
		end
	end
	mbt_tx mbt_tx_i (.I_CLK(clk), .I_ARST_N(arst_n), .I_WR(wr), .I_RD(rd), .I_ADDR(addr),
		.I_WDATA(wdata), .O_RDATA(rdata), .O_TX_LOAD_IRQ(irq), .O_CODED_OUT_PIN(pin),
		.O_CODED_OUT_OE(oe));
	mbt_rx_model mbt_rx_model_i (.i_clk(clk), .i_irq(irq), .i_pin(pin), .i_plain(plain),
		.i_half(half), .i_nbits(nbits), .o_bits(rx_bits), .o_cnt(rx_cnt), .o_bad(rx_bad));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_of_test
	// one-cycle write strobe, held until the taking edge
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// read data is registered, so sample two cycles after the address lands
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		#1 v = rdata;
	endtask : rd_reg
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd_reg(a, v);
		`CHK(v, e)
	endtask : rd_chk
	task automatic wait_idle();
		logic [7:0] v;
		for (int i = 0; i < 200; i++) begin
			rd_reg(ADDR_STATUS, v);
			if (v[0] === 1'b0) return;
		end
		miscompares++;
		end_of_test();
	endtask : wait_idle
	// stop, set mode and divider, then count before buffer
	task automatic send(input logic [7:0] ctl, input logic [7:0] k, input logic [2:0] s,
		input logic [2:0] n, input logic [7:0] dat);
		logic [7:0] v;
		int n0;
		plain <= ctl[BIT_FORMAT];
		half <= ((k < 8'h04) ? 8'h04 : k) << s;
		nbits <= {1'b0, n} + 4'h1;
		exp_bits = 8'h00;
		for (int i = 0; i <= n; i++) begin
			exp_bits = {exp_bits[6:0], ctl[BIT_FIRST] ? dat[i] : dat[7 - i]};
		end
		n0 = irqs;
		wr_reg(ADDR_CTL0, 8'h00);
		wr_reg(ADDR_CTL1, {5'h00, s});
		wr_reg(ADDR_CTL2, k);
		wr_reg(ADDR_CTL0, ctl);
		wr_reg(ADDR_BITCNT, {5'h00, n});
		wr_reg(ADDR_TXBUF, dat);
		rd_reg(ADDR_STATUS, v);
		`CHK(v[0], 1'b1)
		wait_idle();
		`CHK(irqs - n0, 1)
		`CHK(rx_cnt, nbits)
		`CHK(rx_bits, exp_bits)
		`CHK(rx_bad, 1'b0)
		`CHK(pin, ctl[BIT_IDLE])
		$display("word %h done", dat);
	endtask : send
	// two words back to back at k 4, sel 0; the second buffer write lands m + 4 cycles after the first load pulse rises
	task automatic pair(input logic [7:0] ctl, input logic [2:0] n, input logic [7:0] d0,
		input logic [7:0] d1, input int m, input bit late);
		logic [7:0] v, e0, e1;
		int n0;
		plain <= ctl[BIT_FORMAT];
		half <= 8'h04;
		nbits <= {1'b0, n} + 4'h1;
		e0 = 8'h00;
		e1 = 8'h00;
		for (int i = 0; i <= n; i++) begin
			e0 = {e0[6:0], ctl[BIT_FIRST] ? d0[i] : d0[7 - i]};
			e1 = {e1[6:0], ctl[BIT_FIRST] ? d1[i] : d1[7 - i]};
		end
		n0 = irqs;
		wr_reg(ADDR_CTL0, 8'h00);
		wr_reg(ADDR_CTL1, 8'h00);
		wr_reg(ADDR_CTL2, 8'h04);
		wr_reg(ADDR_CTL0, ctl);
		wr_reg(ADDR_BITCNT, {5'h00, n});
		wr_reg(ADDR_TXBUF, d0);
		@(posedge clk);
		#1;
		`CHK(irq, 1'b1)
		wr_reg(ADDR_BITCNT, {5'h00, n});
		repeat (m) @(posedge clk);
		wr_reg(ADDR_TXBUF, d1);
		rd_reg(ADDR_STATUS, v);
		`CHK(v[0], 1'b1)
		wait_idle();
		`CHK(irqs - n0, 2)
		// a bit lasts 2k base clocks, so 8 clocks per bit here
		`CHK(irq_gap, 8 * (n + 1) + (late ? LATE_RESTART_CLKS : 0))
		`CHK(prev_cnt, nbits)
		`CHK(prev_bits, e0)
		`CHK(prev_bad, 1'b0)
		`CHK(rx_cnt, nbits)
		`CHK(rx_bits, e1)
		`CHK(rx_bad, 1'b0)
		`CHK(pin, ctl[BIT_IDLE])
		$display("pair %h %h done", d0, d1);
	endtask : pair
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		#1;
		`CHK(oe, 1'b0)
		`CHK(pin, 1'b0)
		rd_chk(ADDR_CTL0, RST_CTL0);
		rd_chk(ADDR_PORT3_DIR, RST_PORT3_DIR);
		rd_chk(ADDR_CTL1, RST_CTL1);
		rd_chk(ADDR_CTL2, RST_CTL2);
		rd_chk(ADDR_BITCNT, RST_BITCNT);
		wr_reg(16'hff60, 8'h5a);
		rd_chk(16'hff60, 8'h00);
		$display("reset values done");
		wr_reg(ADDR_PORT3_DIR, 8'hfb);
		rd_chk(ADDR_PORT3_DIR, 8'hfb);
		`CHK(oe, 1'b1)
		wr_reg(ADDR_TXBUF, 8'h55);
		repeat (20) @(posedge clk);
		#1;
		`CHK(irqs, 0)
		`CHK(pin, 1'b0)
		$display("disabled write done");
		send(8'h91, 8'h04, 3'h0, 3'h7, 8'h96);
		send(8'h82, 8'h05, 3'h0, 3'h7, 8'ha5);
		send(8'h90, 8'h00, 3'h0, 3'h2, 8'h06);
		send(8'h80, 8'h04, 3'h1, 3'h3, 8'hc3);
		pair(8'h82, 3'h1, 8'h80, 8'h40, 10, 1'b1);
		pair(8'h91, 3'h1, 8'h02, 8'h01, 0, 1'b0);
		// stop in the middle of a word: pin falls back to idle, busy clears
		wr_reg(ADDR_TXBUF, 8'h3c);
		@(posedge clk);
		#1;
		`CHK(irq, 1'b1)
		wr_reg(ADDR_CTL0, 8'h11);
		repeat (2) @(posedge clk);
		#1;
		`CHK(pin, 1'b1)
		rd_chk(ADDR_STATUS, 8'h00);
		$display("stop in mid word done");
		end_of_test();
	end
endmodule : mbt_tx_test
`default_nettype wire
